/* File: sim_map.svh */
// Register offsets, field positions, reset values and function codes
`ifndef SIM_MAP_SVH
`define SIM_MAP_SVH

`define SIM_ADDR_W        4
`define SIM_DATA_W        16

// Function code registers, one per input, at offsets 0x0 .. 0x7
`define SIM_OFS_CODE0     4'h0
`define SIM_OFS_MODE      4'h8
`define SIM_OFS_LIMIT     4'h9
`define SIM_OFS_RAMP      4'hA
`define SIM_OFS_STATUS    4'hB
`define SIM_OFS_SELECT    4'hC
`define SIM_OFS_SCALE     4'hD

// Mode setting fields
`define SIM_MODE_BASE_LSB 0
`define SIM_MODE_POS_SEQ  2

// Limit enable fields
`define SIM_LIM_TORQUE    0
`define SIM_LIM_VELOCITY  1

`define SIM_RST_CODE      8'h00
`define SIM_RST_MODE      3'h0
`define SIM_RST_LIMIT     2'h0
`define SIM_RST_RAMP      16'h0100
`define SIM_SCALE_FULL    16'hFFFF

// Input function codes
`define SIM_FN_NONE       8'h00
`define SIM_FN_REVERSE    8'h06
`define SIM_FN_HALT       8'h07
`define SIM_FN_START      8'h08
`define SIM_FN_TRQ_LIM    8'h09
`define SIM_FN_VEL_LIM    8'h10
`define SIM_FN_SET_B0     8'h11
`define SIM_FN_SET_B1     8'h12
`define SIM_FN_SET_B2     8'h13
`define SIM_FN_VSEL_B0    8'h14
`define SIM_FN_VSEL_B1    8'h15
`define SIM_FN_TSEL_B0    8'h16
`define SIM_FN_TSEL_B1    8'h17
`define SIM_FN_VEL_POS    8'h18
`define SIM_FN_VEL_TRQ    8'h19
`define SIM_FN_SET_B3     8'h1A
`define SIM_FN_SET_B4     8'h1B
`define SIM_FN_PROBE1     8'h1C

// Only this input may carry the touch probe function
`define SIM_PROBE_INPUT   6

`endif

/* File: sim_pkg.sv */
// Types shared by the servo input function mapper
package sim_pkg;

  typedef enum logic [1:0]
  {
    SIM_MODE_VELOCITY,
    SIM_MODE_TORQUE,
    SIM_MODE_PULSE_TRAIN,
    SIM_MODE_POS_SEQUENCE
  } sim_mode_t;

  typedef logic [7:0][7:0] sim_code_arr_t;

  typedef struct packed
  {
    logic       reverse_rotation;
    logic       halt_request;
    logic       halted;
    logic       torque_limit_on;
    logic       velocity_limit_on;
    logic [4:0] set_index;
    logic [1:0] velocity_ref_sel;
    logic [1:0] torque_ref_sel;
  } sim_motion_t;

endpackage : sim_pkg

/* File: sim_mapper.sv */
// Digital input function mapper for a servo drive
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ns
`include "sim_map.svh"

module sim_mapper
  import sim_pkg::*;
#(
  parameter int N_INPUTS = 8
)
(
  input  wire logic                     ref_clk,
  input  wire logic                     srst,
  input  wire logic [N_INPUTS-1:0]      din,
  input  wire logic [`SIM_ADDR_W-1:0]   reg_addr,
  input  wire logic [`SIM_DATA_W-1:0]   reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [`SIM_DATA_W-1:0]   reg_rdata,
  output sim_mode_t                     op_mode,
  output sim_motion_t                   motion,
  output logic      [`SIM_DATA_W-1:0]   motion_scale,
  output logic                          data_set_start,
  output logic                          probe_trigger
);

  // Level of the input carrying a function; zero if no input carries it
  function automatic logic fn_level(input sim_code_arr_t codes,
                                    input logic [7:0]    lvl,
                                    input logic [7:0]    code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (codes[i] == code)
        hit = hit | lvl[i];
    end
    return hit;
  endfunction : fn_level

  // Whether some input carries a function
  function automatic logic fn_used(input sim_code_arr_t codes,
                                   input logic [7:0]    code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      if (codes[i] == code)
        hit = 1'b1;
    end
    return hit;
  endfunction : fn_used

  // Whether a code names a function that this block carries out
  function automatic logic fn_known(input logic [7:0] code);
    return ((code >= `SIM_FN_REVERSE) && (code <= `SIM_FN_TRQ_LIM))
           || ((code >= `SIM_FN_VEL_LIM) && (code <= `SIM_FN_PROBE1));
  endfunction : fn_known

  // Registers
  sim_code_arr_t             code_reg;
  logic [2:0]                mode_set_reg;
  logic [1:0]                limit_set_reg;
  logic [`SIM_DATA_W-1:0]    ramp_reg;
  logic [`SIM_DATA_W-1:0]    rdata_reg;
  logic [N_INPUTS-1:0]       din_meta_reg;
  logic [N_INPUTS-1:0]       din_sync_reg;
  logic                      start_lvl_reg;
  logic                      probe_lvl_reg;
  logic                      start_reg;
  logic                      probe_reg;
  logic [`SIM_DATA_W-1:0]    scale_reg;
  logic [`SIM_DATA_W-1:0]    scale_next;
  sim_mode_t                 mode_reg;
  sim_mode_t                 mode_next;
  sim_motion_t               motion_reg;
  sim_motion_t               motion_next;

  // Decoded input functions
  wire logic [7:0] lvl;
  wire logic [7:0] fn_mask;
  wire logic       halt_done;
  wire logic       reverse_in;
  wire logic       halt_in;
  wire logic       start_in;
  wire logic       trq_lim_in;
  wire logic       vel_lim_in;
  wire logic [4:0] set_index;
  wire logic [1:0] vel_sel;
  wire logic [1:0] trq_sel;
  wire logic       vel_pos_in;
  wire logic       vel_trq_in;
  wire logic       vel_pos_used;
  wire logic       vel_trq_used;
  wire logic       probe_in;
  wire logic       reverse_ok;
  wire logic       start_edge;
  wire logic       probe_edge;
  wire logic       wr_code;
  wire logic [2:0] wr_idx;
  wire sim_mode_t  base_mode;
  wire sim_mode_t  pos_mode;
  wire logic [`SIM_DATA_W-1:0] rd_mux;
  wire logic [`SIM_DATA_W-1:0] scale_dec;
  wire logic [`SIM_DATA_W-1:0] status_word;
  wire logic [`SIM_DATA_W-1:0] select_word;

  // Inputs with no listed function are masked before any decode
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : g_mask
      assign fn_mask[g] = fn_known(code_reg[g]);
    end
  endgenerate

  assign lvl        = 8'(din_sync_reg) & fn_mask;
  assign reverse_in = fn_level(code_reg, lvl, `SIM_FN_REVERSE);
  assign halt_in    = fn_level(code_reg, lvl, `SIM_FN_HALT);
  assign start_in   = fn_level(code_reg, lvl, `SIM_FN_START);
  assign trq_lim_in = fn_level(code_reg, lvl, `SIM_FN_TRQ_LIM);
  assign vel_lim_in = fn_level(code_reg, lvl, `SIM_FN_VEL_LIM);
  assign set_index  = {fn_level(code_reg, lvl, `SIM_FN_SET_B4),
                       fn_level(code_reg, lvl, `SIM_FN_SET_B3),
                       fn_level(code_reg, lvl, `SIM_FN_SET_B2),
                       fn_level(code_reg, lvl, `SIM_FN_SET_B1),
                       fn_level(code_reg, lvl, `SIM_FN_SET_B0)};
  assign vel_sel    = {fn_level(code_reg, lvl, `SIM_FN_VSEL_B1),
                       fn_level(code_reg, lvl, `SIM_FN_VSEL_B0)};
  assign trq_sel    = {fn_level(code_reg, lvl, `SIM_FN_TSEL_B1),
                       fn_level(code_reg, lvl, `SIM_FN_TSEL_B0)};
  assign vel_pos_in   = fn_level(code_reg, lvl, `SIM_FN_VEL_POS);
  assign vel_trq_in   = fn_level(code_reg, lvl, `SIM_FN_VEL_TRQ);
  assign vel_pos_used = fn_used(code_reg, `SIM_FN_VEL_POS);
  assign vel_trq_used = fn_used(code_reg, `SIM_FN_VEL_TRQ);

  // Probe is honoured only on the dedicated input
  assign probe_in = (code_reg[`SIM_PROBE_INPUT] == `SIM_FN_PROBE1)
                    && lvl[`SIM_PROBE_INPUT];

  // Mode selection; the velocity-position switch wins if both are mapped
  // Base mode applies only while no input carries a mode switch
  assign base_mode = sim_mode_t'(mode_set_reg[`SIM_MODE_BASE_LSB +: 2]);
  assign pos_mode  = mode_set_reg[`SIM_MODE_POS_SEQ] ? SIM_MODE_POS_SEQUENCE
                                                     : SIM_MODE_PULSE_TRAIN;
  assign mode_next = vel_pos_used ? (vel_pos_in ? pos_mode
                                                : SIM_MODE_VELOCITY)
                   : vel_trq_used ? (vel_trq_in ? SIM_MODE_TORQUE
                                                : SIM_MODE_VELOCITY)
                   : base_mode;

  // Mode of the cycle before, so a mode being left keeps reversal for one more cycle
  assign reverse_ok = (mode_reg == SIM_MODE_VELOCITY)
                      || (mode_reg == SIM_MODE_TORQUE);

  // Start and probe act on rising edges only, start only in position sequence mode; a held level fires at most once
  assign start_edge = start_in && !start_lvl_reg
                      && (mode_reg == SIM_MODE_POS_SEQUENCE);
  assign probe_edge = probe_in && !probe_lvl_reg;

  // Halt ramp: scale falls by the ramp step per cycle, saturating at zero
  // A step larger than the remainder would otherwise wrap back to speed
  assign scale_dec  = (scale_reg > ramp_reg) ? scale_reg - ramp_reg
                                             : '0;
  assign scale_next = halt_in ? scale_dec
                              : `SIM_SCALE_FULL;
  assign halt_done  = halt_in && (scale_next == '0);

  always_comb
  begin
    motion_next                   = '0;
    motion_next.reverse_rotation  = reverse_in && reverse_ok;
    motion_next.halt_request      = halt_in;
    motion_next.halted            = halt_done;
    motion_next.torque_limit_on   = trq_lim_in
                                    || limit_set_reg[`SIM_LIM_TORQUE];
    motion_next.velocity_limit_on = vel_lim_in
                                    || limit_set_reg[`SIM_LIM_VELOCITY];
    motion_next.set_index         = set_index;
    motion_next.velocity_ref_sel  = vel_sel;
    motion_next.torque_ref_sel    = trq_sel;
  end

  // Register bus decode
  assign wr_code = reg_wr && (reg_addr < `SIM_OFS_MODE);
  assign wr_idx  = reg_addr[2:0];

  // Read-only words built from the registered state
  assign status_word = {9'h000, mode_reg, motion_reg.reverse_rotation,
                        motion_reg.halt_request, motion_reg.halted,
                        motion_reg.torque_limit_on, motion_reg.velocity_limit_on};
  assign select_word = {7'h00, motion_reg.set_index, motion_reg.velocity_ref_sel,
                        motion_reg.torque_ref_sel};

  assign rd_mux =
      (reg_addr < `SIM_OFS_MODE)  ? {8'h00, code_reg[reg_addr[2:0]]}
    : (reg_addr == `SIM_OFS_MODE)  ? {13'h0000, mode_set_reg}
    : (reg_addr == `SIM_OFS_LIMIT) ? {14'h0000, limit_set_reg}
    : (reg_addr == `SIM_OFS_RAMP)  ? ramp_reg
    : (reg_addr == `SIM_OFS_STATUS) ? status_word
    : (reg_addr == `SIM_OFS_SELECT) ? select_word
    : (reg_addr == `SIM_OFS_SCALE) ? scale_reg
    : '0;

  // Input synchroniser
  // Two stages: the pins are asynchronous to ref_clk
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      din_meta_reg <= '0;
      din_sync_reg <= '0;
    end
    else
    begin
      din_meta_reg <= din;
      din_sync_reg <= din_meta_reg;
    end
  end

  // Software settings
  // Unmapped offsets fall through and leave every setting alone
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < 8; i++)
        code_reg[i] <= `SIM_RST_CODE;
      mode_set_reg  <= `SIM_RST_MODE;
      limit_set_reg <= `SIM_RST_LIMIT;
      ramp_reg      <= `SIM_RST_RAMP;
    end
    else if (reg_wr)
    begin
      if (wr_code)
        code_reg[wr_idx] <= reg_wdata[7:0];
      if (reg_addr == `SIM_OFS_MODE)
        mode_set_reg <= reg_wdata[2:0];
      if (reg_addr == `SIM_OFS_LIMIT)
        limit_set_reg <= reg_wdata[1:0];
      if (reg_addr == `SIM_OFS_RAMP)
        ramp_reg <= reg_wdata;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (srst)
      rdata_reg <= '0;
    else
      rdata_reg <= reg_rd ? rd_mux : '0;
  end

  // Motion state
  // Edge detectors reset low, matching idle inputs, so release gives no pulse
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      mode_reg      <= SIM_MODE_VELOCITY;
      motion_reg    <= '0;
      scale_reg     <= `SIM_SCALE_FULL;
      start_lvl_reg <= 1'b0;
      probe_lvl_reg <= 1'b0;
      start_reg     <= 1'b0;
      probe_reg     <= 1'b0;
    end
    else
    begin
      mode_reg      <= mode_next;
      motion_reg    <= motion_next;
      scale_reg     <= scale_next;
      start_lvl_reg <= start_in;
      probe_lvl_reg <= probe_in;
      start_reg     <= start_edge;
      probe_reg     <= probe_edge;
    end
  end

  assign reg_rdata      = rdata_reg;
  assign op_mode        = mode_reg;
  assign motion         = motion_reg;
  assign motion_scale   = scale_reg;
  assign data_set_start = start_reg;
  assign probe_trigger  = probe_reg;

endmodule : sim_mapper

/* File: sim_mapper_chk.sv */
// Port-level assertions for the servo input function mapper
`timescale 1ns/1ns
`include "sim_map.svh"
module sim_mapper_chk
  import sim_pkg::*;
#(
  parameter int N_INPUTS = 8
)
(
  input wire logic                   ref_clk,
  input wire logic                   srst,
  input wire logic [N_INPUTS-1:0]    din,
  input wire logic [`SIM_ADDR_W-1:0] reg_addr,
  input wire logic [`SIM_DATA_W-1:0] reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [`SIM_DATA_W-1:0] reg_rdata,
  input wire sim_mode_t              op_mode,
  input wire sim_motion_t            motion,
  input wire logic [`SIM_DATA_W-1:0] motion_scale,
  input wire logic                   data_set_start,
  input wire logic                   probe_trigger
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  property p_status; reg_rd && reg_addr == `SIM_OFS_STATUS |=> reg_rdata[6:5] == $past(op_mode);
  endproperty
  a_status: assert property (p_status) else $error("status mode field wrong");
  property p_reverse; motion.reverse_rotation |->
    $past(op_mode) inside {SIM_MODE_VELOCITY, SIM_MODE_TORQUE}; endproperty
  a_reverse: assert property (p_reverse) else $error("reversal in wrong mode");
  // Mode may move in the same edge as the pulse, so either side of it counts
  property p_start; data_set_start |-> (op_mode == SIM_MODE_POS_SEQUENCE ||
    $past(op_mode) == SIM_MODE_POS_SEQUENCE) ##1 !data_set_start; endproperty
  a_start: assert property (p_start) else $error("bad data set start");
  property p_probe; probe_trigger |-> $past(din[`SIM_PROBE_INPUT], 3) &&
    !$past(din[`SIM_PROBE_INPUT], 4) ##1 !probe_trigger; endproperty
  a_probe: assert property (p_probe) else $error("probe pulse without input edge");
  property p_halted; motion.halted |->
    motion_scale == 16'h0000 || $past(motion_scale) == 16'h0000; endproperty
  a_halted: assert property (p_halted) else $error("halted with motion left");
  property p_ramp; motion.halt_request && $past(motion.halt_request) |->
    motion_scale <= $past(motion_scale); endproperty
  a_ramp: assert property (p_ramp) else $error("scale rose during halt");
  property p_resume; (!motion.halt_request)[*2] |-> motion_scale == 16'hFFFF; endproperty
  a_resume: assert property (p_resume) else $error("motion not resumed");
endmodule : sim_mapper_chk

/* File: sim_ctrl_model.sv */
// External controller driving the digital signal inputs
`timescale 1ns/1ns
module sim_ctrl_model
(
  input  wire logic       ref_clk,
  input  wire logic [7:0] lvl,
  output logic      [7:0] din
);
  // Levels change just after an edge, so the drive sees them as asynchronous
  initial din = 8'h00;
  always @(posedge ref_clk)
    din <= lvl;
endmodule : sim_ctrl_model

/* File: sim_mapper_tb_top.sv */
// Self-checking bench for the servo input function mapper
`timescale 1ns/1ns
`include "sim_map.svh"
module sim_mapper_tb_top;
  import sim_pkg::*;
  logic        ref_clk = 1'b0;
  logic        srst = 1'b1;
  logic [7:0]  lvl = 8'h00;
  logic [7:0]  din;
  logic [3:0]  reg_addr = 4'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  sim_mode_t   op_mode;
  sim_motion_t motion;
  logic [15:0] motion_scale;
  logic        data_set_start;
  logic        probe_trigger;
  int          n_mismatch = 0;
  int          tests_run = 0;
  always #5 ref_clk = ~ref_clk;
  sim_ctrl_model ctrl (.ref_clk(ref_clk), .lvl(lvl), .din(din));
  sim_mapper dut (.ref_clk(ref_clk), .srst(srst), .din(din), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_mode(op_mode), .motion(motion), .motion_scale(motion_scale),
    .data_set_start(data_set_start), .probe_trigger(probe_trigger));
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", reg_rdata, exp);
  endtask : rd
  // Covers the model's register, the synchroniser and the mode-to-reverse lag
  task automatic drv(input logic [7:0] v);
    @(posedge ref_clk);
    lvl <= v;
    repeat (6) @(posedge ref_clk);
    #1;
  endtask : drv
  task automatic pulse(input logic [7:0] v, input logic sel, input logic [15:0] exp);
    int k;
    logic [15:0] n;
    n = 16'h0000;
    @(posedge ref_clk);
    lvl <= v;
    for (k = 0; k < 10; k++)
    begin
      @(posedge ref_clk);
      #1;
      if ((sel ? probe_trigger : data_set_start) === 1'b1)
        n++;
    end
    chk("pulse count", n, exp);
  endtask : pulse
  task automatic report_and_stop;
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  initial
  begin
    int i;
    logic [4:0] p;
    logic [1:0] v;
    logic [15:0] first;
    repeat (8) @(posedge ref_clk);
    srst <= 1'b0;
    for (i = 0; i < 8; i++)
      rd(4'(i), 16'h0000);
    rd(4'h8, 16'h0000);
    rd(4'h9, 16'h0000);
    rd(4'hA, 16'h0100);
    rd(4'hB, 16'h0000);
    rd(4'hD, 16'hFFFF);
    wr(4'hE, 16'h1234);
    rd(4'hE, 16'h0000);
    rd(4'hF, 16'h0000);
    wr(4'h0, 16'h0006);
    wr(4'h5, 16'h0019);
    rd(4'h5, 16'h0019);
    drv(8'h01);
    chk("reverse", 16'(motion.reverse_rotation), 16'h0001);
    chk("op_mode", 16'(op_mode), 16'(SIM_MODE_VELOCITY));
    drv(8'h21);
    chk("op_mode", 16'(op_mode), 16'(SIM_MODE_TORQUE));
    chk("reverse", 16'(motion.reverse_rotation), 16'h0001);
    wr(4'h5, 16'h0018);
    drv(8'h21);
    chk("op_mode", 16'(op_mode), 16'(SIM_MODE_PULSE_TRAIN));
    chk("reverse", 16'(motion.reverse_rotation), 16'h0000);
    wr(4'h8, 16'h0004);
    rd(4'h8, 16'h0004);
    drv(8'h21);
    chk("op_mode", 16'(op_mode), 16'(SIM_MODE_POS_SEQUENCE));
    wr(4'h1, 16'h0009);
    wr(4'h2, 16'h0010);
    drv(8'h02);
    chk("limits", 16'({motion.torque_limit_on, motion.velocity_limit_on}), 16'h0002);
    drv(8'h04);
    chk("limits", 16'({motion.torque_limit_on, motion.velocity_limit_on}), 16'h0001);
    wr(4'h9, 16'h0001);
    drv(8'h00);
    chk("limits", 16'({motion.torque_limit_on, motion.velocity_limit_on}), 16'h0002);
    wr(4'h9, 16'h0002);
    drv(8'h00);
    chk("limits", 16'({motion.torque_limit_on, motion.velocity_limit_on}), 16'h0001);
    wr(4'h9, 16'h0000);
    wr(4'h3, 16'h0011);
    wr(4'h4, 16'h0012);
    wr(4'h5, 16'h0013);
    wr(4'h6, 16'h001A);
    wr(4'h7, 16'h001B);
    for (i = 0; i < 6; i++)
    begin
      p = (i < 5) ? 5'(1 << i) : 5'h16;
      drv({p, 3'h0});
      chk("set_index", 16'(motion.set_index), 16'(p));
    end
    rd(4'hC, 16'h0160);
    wr(4'h0, 16'h0014);
    wr(4'h1, 16'h0015);
    wr(4'h2, 16'h0016);
    wr(4'h3, 16'h0017);
    for (i = 0; i < 4; i++)
    begin
      v = 2'(i);
      drv({4'h0, ~v, v});
      chk("velocity_ref_sel", 16'(motion.velocity_ref_sel), 16'(v));
      chk("torque_ref_sel", 16'(motion.torque_ref_sel), {14'h0000, ~v});
    end
    for (i = 0; i < 7; i++)
      wr(4'(i), 16'h0000);
    wr(4'h7, 16'h002F);
    drv(8'hFF);
    chk("motion", 16'(motion), 16'h0000);
    chk("op_mode", 16'(op_mode), 16'(SIM_MODE_VELOCITY));
    wr(4'h8, 16'h0005);
    drv(8'hFF);
    chk("op_mode", 16'(op_mode), 16'(SIM_MODE_TORQUE));
    drv(8'h00);
    wr(4'h0, 16'h0008);
    wr(4'h1, 16'h0018);
    drv(8'h02);
    pulse(8'h03, 1'b0, 16'h0001);
    drv(8'h00);
    pulse(8'h01, 1'b0, 16'h0000);
    wr(4'h0, 16'h001C);
    drv(8'h00);
    pulse(8'h01, 1'b1, 16'h0000);
    wr(4'h0, 16'h0000);
    wr(4'h6, 16'h001C);
    pulse(8'h40, 1'b1, 16'h0001);
    wr(4'h1, 16'h0007);
    wr(4'hA, 16'h4000);
    drv(8'h00);
    first = 16'hFFFF;
    @(posedge ref_clk);
    lvl <= 8'h02;
    for (i = 0; i < 20 && motion.halted !== 1'b1; i++)
    begin
      @(posedge ref_clk);
      #1;
      if (motion_scale !== 16'hFFFF && first === 16'hFFFF)
        first = motion_scale;
    end
    if (i == 20)
    begin
      n_mismatch++;
      report_and_stop();
    end
    chk("first step", first, 16'hBFFF);
    chk("halt_request", 16'(motion.halt_request), 16'h0001);
    rd(4'hB, 16'h002C);
    chk("motion_scale", motion_scale, 16'h0000);
    drv(8'h00);
    chk("motion_scale", motion_scale, 16'hFFFF);
    chk("halted", 16'(motion.halted), 16'h0000);
    report_and_stop();
  end
endmodule : sim_mapper_tb_top
bind sim_mapper sim_mapper_chk #(.N_INPUTS(N_INPUTS)) chk (.ref_clk(ref_clk), .srst(srst),
  .din(din), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .op_mode(op_mode), .motion(motion), .motion_scale(motion_scale),
  .data_set_start(data_set_start), .probe_trigger(probe_trigger));
